// ===== hw/etvs_core.sv
// virtual energy and temperature scaling datapath
`timescale 1ns/1ps
module etvs_core (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire etvs_pkg::etvs_raw_t           raw,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	input  wire logic [etvs_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [etvs_pkg::COEF_W-1:0]   reg_wdata,
	output logic      [etvs_pkg::COEF_W-1:0]   reg_rdata,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	input  wire logic [etvs_pkg::ADDR_W-1:0]   req_addr,
	output logic                               out_valid,
	input  wire logic                          out_ready,
	output logic      [7:0]                    out_data,
	output logic                               out_last
);
	logic [etvs_pkg::COEF_W-1:0] energy_scale_coeff;
	logic [etvs_pkg::COEF_W-1:0] temperature_scale_coeff;
	logic [etvs_pkg::COEF_W-1:0] next_energy_scale_coeff;
	logic [etvs_pkg::COEF_W-1:0] next_temperature_scale_coeff;
	logic [etvs_pkg::COEF_W-1:0] next_reg_rdata;

	etvs_pkg::etvs_state_t       state;
	etvs_pkg::etvs_state_t       next_state;
	logic [etvs_pkg::ADDR_W-1:0] addr;
	logic [etvs_pkg::ADDR_W-1:0] next_addr;
	logic [etvs_pkg::NET_W-1:0]  operand;
	logic [etvs_pkg::NET_W-1:0]  next_operand;
	logic                        is_temp;
	logic                        next_is_temp;
	logic [63:0]                 shift;
	logic [63:0]                 next_shift;
	logic [2:0]                  cnt;
	logic [2:0]                  next_cnt;
	logic [7:0]                  req_group;
	logic [3:0]                  req_phase;

	logic [etvs_pkg::NET_W-1:0] net [etvs_pkg::KINDS][etvs_pkg::PHASES];

	localparam int EXT = etvs_pkg::NET_W - etvs_pkg::ACC_W;

	// modulo subtraction in the wider width yields a proper signed net
	for (genvar p = 0; p < etvs_pkg::PHASES; p++) begin : g_phase
		assign net[0][p] = {{EXT{1'b0}}, raw.real_energy_forward_acc[p]}
			- {{EXT{1'b0}}, raw.real_energy_reverse_acc[p]};
		assign net[1][p] = {{EXT{1'b0}}, raw.reactive_energy_forward_acc[p]}
			- {{EXT{1'b0}}, raw.reactive_energy_reverse_acc[p]};
		assign net[3][p] = {{EXT{1'b0}}, raw.real_fund_forward_acc[p]}
			- {{EXT{1'b0}}, raw.real_fund_reverse_acc[p]};
		assign net[4][p] = {{EXT{1'b0}}, raw.reactive_fund_forward_acc[p]}
			- {{EXT{1'b0}}, raw.reactive_fund_reverse_acc[p]};
		assign net[2][p] = {{EXT{1'b0}}, raw.apparent_energy_acc[p]};
		assign net[5][p] = {{EXT{1'b0}},
			raw.apparent_fundamental_energy_acc[p]};
	end

	// register file
	// read data holds until the next read, so a slow host may sample late
	always_comb begin
		next_energy_scale_coeff      = energy_scale_coeff;
		next_temperature_scale_coeff = temperature_scale_coeff;
		next_reg_rdata               = reg_rdata;
		if (reg_wr && reg_addr == etvs_pkg::OFS_ENERGY_COEFF) begin
			next_energy_scale_coeff = reg_wdata;
		end
		if (reg_wr && reg_addr == etvs_pkg::OFS_TEMP_COEFF) begin
			next_temperature_scale_coeff = reg_wdata;
		end
		if (reg_rd) begin
			unique case (reg_addr)
				etvs_pkg::OFS_ENERGY_COEFF: next_reg_rdata = energy_scale_coeff;
				etvs_pkg::OFS_TEMP_COEFF:
					next_reg_rdata = temperature_scale_coeff;
				// offsets outside the map read as zero
				default: next_reg_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			energy_scale_coeff      <= etvs_pkg::RST_ENERGY_COEFF;
			temperature_scale_coeff <= etvs_pkg::RST_TEMP_COEFF;
			reg_rdata               <= '0;
		end else begin
			energy_scale_coeff      <= next_energy_scale_coeff;
			temperature_scale_coeff <= next_temperature_scale_coeff;
			reg_rdata               <= next_reg_rdata;
		end
	end

	// operand selection
	function automatic logic [etvs_pkg::NET_W-1:0] pick(
		input logic [etvs_pkg::NET_W-1:0] a,
		input logic [etvs_pkg::NET_W-1:0] b,
		input logic [etvs_pkg::NET_W-1:0] c,
		input logic [3:0]                 ph
	);
		logic [etvs_pkg::NET_W-1:0] r;
		r = '0;
		unique case (ph)
			etvs_pkg::PH_A: r = a;
			etvs_pkg::PH_B: r = b;
			etvs_pkg::PH_C: r = c;
			etvs_pkg::PH_T: r = a + b + c;
			default: r = '0;
		endcase
		return r;
	endfunction

	logic signed [etvs_pkg::PROD_W-1:0]  eprod;
	logic        [etvs_pkg::TPROD_W-1:0] tprod;
	logic        [etvs_pkg::VAL_W-1:0]   tval;
	logic        [etvs_pkg::VAL_W-1:0]   value;
	logic        [etvs_pkg::NET_W-1:0]   sel;
	logic        [2:0]                   kind;

	assign eprod = $signed(operand) * $signed({1'b0, energy_scale_coeff});
	// widen every factor first so the product cannot wrap
	// raw times coeff times 100, shift 16, minus offset
	assign tprod = etvs_pkg::TPROD_W'(raw.raw_temperature)
		* etvs_pkg::TPROD_W'(temperature_scale_coeff)
		* etvs_pkg::TPROD_W'(etvs_pkg::TEMP_SCALE);
	assign tval  = etvs_pkg::VAL_W'(tprod >> etvs_pkg::TFRAC_W)
		- etvs_pkg::TEMP_OFFSET;
	assign value = is_temp ? tval : eprod[etvs_pkg::VAL_W-1:0];

	// upper byte picks the value group, low nibble the phase
	assign {req_group, req_phase} = addr;

	always_comb begin
		kind = 3'h7;
		unique case (req_group)
			etvs_pkg::GRP_REAL:   kind = 3'h0;
			etvs_pkg::GRP_REACT:  kind = 3'h1;
			etvs_pkg::GRP_APP:    kind = 3'h2;
			etvs_pkg::GRP_REALF:  kind = 3'h3;
			etvs_pkg::GRP_REACTF: kind = 3'h4;
			etvs_pkg::GRP_APPF:   kind = 3'h5;
			default:              kind = 3'h7;
		endcase
		sel = '0;
		// groups outside the table answer zero
		if (kind < 3'(etvs_pkg::KINDS)) begin
			sel = pick(net[kind][0], net[kind][1], net[kind][2], req_phase);
		end
	end

	always_comb begin
		next_state   = state;
		next_addr    = addr;
		next_operand = operand;
		next_is_temp = is_temp;
		next_shift   = shift;
		next_cnt     = cnt;
		unique case (state)
			etvs_pkg::ETVS_IDLE: begin
				if (req_valid) begin
					next_addr  = req_addr;
					next_state = etvs_pkg::ETVS_SELECT;
				end
			end
			etvs_pkg::ETVS_SELECT: begin
				// latched so the multiplier never sees the select path
				next_operand = sel;
				next_is_temp = (addr == etvs_pkg::CMD_TEMPERATURE);
				next_state   = etvs_pkg::ETVS_SCALE;
			end
			etvs_pkg::ETVS_SCALE: begin
				next_shift = {{etvs_pkg::PAD_W{1'b0}}, value};
				next_cnt   = '0;
				next_state = etvs_pkg::ETVS_SEND;
			end
			etvs_pkg::ETVS_SEND: begin
				// host may stall; the byte stands until taken
				if (out_ready) begin
					next_shift = {8'h00, shift[63:8]};
					next_cnt   = cnt + 3'h1;
					if (cnt == etvs_pkg::LAST_BYTE) begin
						next_state = etvs_pkg::ETVS_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state   <= etvs_pkg::ETVS_IDLE;
			addr    <= '0;
			operand <= '0;
			is_temp <= 1'b0;
			shift   <= '0;
			cnt     <= '0;
		end else begin
			state   <= next_state;
			addr    <= next_addr;
			operand <= next_operand;
			is_temp <= next_is_temp;
			shift   <= next_shift;
			cnt     <= next_cnt;
		end
	end

	assign req_ready = (state == etvs_pkg::ETVS_IDLE);
	assign out_valid = (state == etvs_pkg::ETVS_SEND);
	assign out_data  = shift[7:0];
	assign out_last  = out_valid && (cnt == etvs_pkg::LAST_BYTE);
endmodule

// ===== hw/etvs_pkg.sv
// constants and types for the virtual energy and temperature scaling block
// Functional notes
// - energy value = raw energy times energy coefficient
// - energy coefficient resets to 0x0001
// - real/reactive views are scaled forward minus reverse
// - apparent views scale the single apparent accumulator
// - temperature = raw times coeff / 2^16 - 273.15
// - command 0xC01 returns the converted temperature
// - values computed on request, with added latency
// - eight bytes sent least significant byte first
// - top two bytes zero, bit 47 sign
// - real and reactive energy views are signed
package etvs_pkg;
	localparam int ACC_W     = 32;
	localparam int NET_W     = ACC_W + 3;
	localparam int COEF_W    = 16;
	localparam int VAL_W     = 48;
	localparam int PAD_W     = 16;
	localparam int TEMP_W    = 16;
	localparam int ADDR_W    = 12;
	localparam int PHASES    = 3;
	localparam int KINDS     = 6;
	localparam int PROD_W    = NET_W + COEF_W + 1;
	localparam int TPROD_W   = TEMP_W + COEF_W + 7;
	localparam int TFRAC_W   = 16;

	localparam logic [ADDR_W-1:0] OFS_ENERGY_COEFF = 12'h01a;
	localparam logic [ADDR_W-1:0] OFS_TEMP_COEFF   = 12'h060;
	localparam logic [COEF_W-1:0] RST_ENERGY_COEFF = 16'h0001;
	localparam logic [COEF_W-1:0] RST_TEMP_COEFF   = 16'h0000;

	localparam logic [ADDR_W-1:0] CMD_TEMPERATURE  = 12'hc01;
	localparam logic [7:0] GRP_REAL    = 8'h8c;
	localparam logic [7:0] GRP_REACT   = 8'h8d;
	localparam logic [7:0] GRP_APP     = 8'h87;
	localparam logic [7:0] GRP_REALF   = 8'h8e;
	localparam logic [7:0] GRP_REACTF  = 8'h8f;
	localparam logic [7:0] GRP_APPF    = 8'h88;
	localparam logic [3:0] PH_A        = 4'h1;
	localparam logic [3:0] PH_B        = 4'h2;
	localparam logic [3:0] PH_C        = 4'h4;
	localparam logic [3:0] PH_T        = 4'h7;

	// temperature reported in hundredths of a degree
	localparam logic [6:0]  TEMP_SCALE  = 7'h64;
	localparam logic [VAL_W-1:0] TEMP_OFFSET = 48'h0000_0000_6ab3;
	localparam logic [2:0]  LAST_BYTE   = 3'h7;

	typedef enum logic [1:0] {
		ETVS_IDLE   = 2'b00,
		ETVS_SELECT = 2'b01,
		ETVS_SCALE  = 2'b10,
		ETVS_SEND   = 2'b11
	} etvs_state_t;

	typedef struct packed {
		logic [PHASES-1:0][ACC_W-1:0] real_energy_forward_acc;
		logic [PHASES-1:0][ACC_W-1:0] real_energy_reverse_acc;
		logic [PHASES-1:0][ACC_W-1:0] reactive_energy_forward_acc;
		logic [PHASES-1:0][ACC_W-1:0] reactive_energy_reverse_acc;
		logic [PHASES-1:0][ACC_W-1:0] real_fund_forward_acc;
		logic [PHASES-1:0][ACC_W-1:0] real_fund_reverse_acc;
		logic [PHASES-1:0][ACC_W-1:0] reactive_fund_forward_acc;
		logic [PHASES-1:0][ACC_W-1:0] reactive_fund_reverse_acc;
		logic [PHASES-1:0][ACC_W-1:0] apparent_energy_acc;
		logic [PHASES-1:0][ACC_W-1:0] apparent_fundamental_energy_acc;
		logic [TEMP_W-1:0]            raw_temperature;
	} etvs_raw_t;
endpackage

// ===== sim/etvs_host.sv
// host model collecting virtual value bytes
`timescale 1ns/1ps
module etvs_host (
	input	wire logic		clk,
	input	wire logic		slow,
	input	wire logic		out_valid,
	input	wire logic [7:0]	out_data,
	input	wire logic		out_last,
	output	logic			out_ready,
	output	logic [63:0]		word = 64'h0,
	output	logic			done = 1'b0
);
	logic [2:0]	n = 3'h0;
	logic		tog = 1'b0;
	assign out_ready = !slow || tog;
	always @(posedge clk) begin
		tog <= !tog;
		done <= 1'b0;
		if (out_valid && out_ready) begin
			word[8*n +: 8] <= out_data;
			n <= n + 3'h1;
			done <= out_last;
		end
	end
endmodule

// ===== sim/etvs_core_sva.sv
// port assertions for the scaling block
`timescale 1ns/1ps
module etvs_core_sva (
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic		reg_rd,
	input	wire logic [11:0]	reg_addr,
	input	wire logic [15:0]	reg_rdata,
	input	wire logic		req_valid,
	input	wire logic		req_ready,
	input	wire logic		out_valid,
	input	wire logic		out_ready,
	input	wire logic [7:0]	out_data,
	input	wire logic		out_last
);
	// byte position, reset with the block so a cut frame restarts
	logic [2:0]	idx;
	always_ff @(posedge clk or posedge rst)
		if (rst)
			idx <= 3'h0;
		else if (out_valid && out_ready)
			idx <= idx + 3'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_busy_refuse: assert property (
		out_valid |-> !req_ready) else $error("busy accept");
	chk_answer_delay: assert property (
		req_valid && req_ready |=> !out_valid ##1 !out_valid ##1 out_valid)
		else $error("answer delay");
	chk_byte_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("byte dropped");
	chk_last_place: assert property (
		out_valid |-> out_last == (idx == 3'h7)) else $error("last misplaced");
	chk_top_zero: assert property (
		out_valid && idx[2:1] == 2'b11 |-> out_data == 8'h00)
		else $error("top bytes");
	chk_frame_end: assert property (
		out_valid && out_ready && out_last |=> req_ready && !out_valid)
		else $error("frame end");
	chk_rd_unmapped: assert property (
		reg_rd && reg_addr != 12'h01a && reg_addr != 12'h060
		|=> reg_rdata == 16'h0000) else $error("unmapped read");
	chk_rd_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule
bind etvs_core etvs_core_sva u_sva (.*);

// ===== sim/tb_top.sv
// self-checking bench for the scaling block
`timescale 1ns/1ps
module tb_top;
	logic			clk = 1'b0;
	logic			rst = 1'b1;
	etvs_pkg::etvs_raw_t	raw;
	logic			reg_wr = 1'b0;
	logic			reg_rd = 1'b0;
	logic [11:0]		reg_addr = 12'h000;
	logic [15:0]		reg_wdata = 16'h0000;
	logic [15:0]		reg_rdata;
	logic			req_valid = 1'b0;
	logic			req_ready;
	logic [11:0]		req_addr = 12'h000;
	logic			out_valid, out_ready, out_last, done;
	logic			slow = 1'b0;
	logic [7:0]		out_data;
	logic [63:0]		word;
	logic [15:0]		ec = 16'h0001;
	logic [15:0]		tc = 16'h0000;
	logic [7:0]		grp [6] = '{etvs_pkg::GRP_REAL, etvs_pkg::GRP_REACT,
		etvs_pkg::GRP_REALF, etvs_pkg::GRP_REACTF, etvs_pkg::GRP_APP,
		etvs_pkg::GRP_APPF};
	logic [3:0]		nib [5] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h3};
	int			miscompares = 0;
	int			checked = 0;
	always #25 clk = ~clk;
	etvs_core DUT (.*);
	etvs_host host (.*);
	function automatic logic [47:0] acc(input int k, input int p);
		return (k < 0) ? 48'h0 : 48'(raw[16+96*(9-k)+32*p +: 32]);
	endfunction
	// forward minus reverse, summed for totals, then scaled
	function automatic logic [47:0] ev(input int j, input logic [3:0] n);
		logic [47:0]	s;
		int		f;
		s = 48'h0;
		f = (j < 4) ? 2 * j : j + 4;
		for (int p = 0; p < 3; p++)
			if (n == 4'h7 || n == (4'h1 << p))
				s = s + acc(f, p) - acc((j < 4) ? f + 1 : -1, p);
		return s * 48'(ec);
	endfunction
	function automatic logic [47:0] tv();
		return 48'(((64'(raw.raw_temperature) * tc * 100) >> 16) - 27315);
	endfunction
	task cmp(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		cmp({48'h0, reg_rdata}, {48'h0, e});
	endtask
	task get(input logic [11:0] a, input logic [47:0] e);
		@(negedge clk);
		req_valid = 1'b1;
		req_addr = a;
		while (!req_ready) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		repeat (60) begin
			@(posedge clk);
			#1;
			if (done) break;
		end
		cmp({63'h0, done}, 64'h1);
		cmp(word, {16'h0000, e});
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 30; i++)
			raw[16+32*i +: 32] = 32'(32'h0123_4567 * (i ^ 5));
		raw.raw_temperature = 16'hb000;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		rd(12'h01a, 16'h0001);
		rd(12'h060, 16'h0000);
		rd(12'h05e, 16'h0000);
		get(12'h8c1, ev(0, 4'h1));
		get(12'hc01, tv());
		ec = 16'h2f3d;
		tc = 16'h0426;
		wr(12'h01a, ec);
		wr(12'h060, tc);
		rd(12'h01a, ec);
		rd(12'h060, tc);
		get(12'hc01, tv());
		// every group and phase code, codes 2 and 7 with a stalling host
		for (int j = 0; j < 6; j++)
			for (int n = 0; n < 5; n++) begin
				slow = n[0];
				get({grp[j], nib[n]}, ev(j, nib[n]));
			end
		get(12'h8b1, 48'h0);
		get(12'h877, ev(4, 4'h7));
		get(12'h884, ev(5, 4'h4));
		get(12'h8c2, ev(0, 4'h2));
		cmp({63'h0, word[47]}, 64'h1);
		finish_test;
	end
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		finish_test;
	end
endmodule
